// file: fdmon_pkg.sv
// package for the fast-detect dwell and signal monitor block
// assumes an 8-bit register port with 12-bit addresses on the output clock
package fdmon_pkg;
    localparam logic [11:0] ADDR_FD_UP_LOW       = 12'h247;
    localparam logic [11:0] ADDR_FD_UP_HIGH      = 12'h248;
    localparam logic [11:0] ADDR_FD_LOW_LOW      = 12'h249;
    localparam logic [11:0] ADDR_FD_LOW_HIGH     = 12'h24a;
    localparam logic [11:0] ADDR_FD_DWELL_LOW    = 12'h24b;
    localparam logic [11:0] ADDR_FD_DWELL_HIGH   = 12'h24c;
    localparam logic [11:0] ADDR_MON_SYNC_CTRL   = 12'h26f;
    localparam logic [11:0] ADDR_MON_CTRL        = 12'h270;
    localparam logic [11:0] ADDR_MON_PERIOD_LOW  = 12'h271;
    localparam logic [11:0] ADDR_MON_PERIOD_MID  = 12'h272;
    localparam logic [11:0] ADDR_MON_PERIOD_HIGH = 12'h273;
    localparam logic [11:0] ADDR_MON_PEAK_LOW    = 12'h275;
    localparam logic [11:0] ADDR_MON_PEAK_MID    = 12'h276;
    localparam logic [11:0] ADDR_MON_PEAK_HIGH   = 12'h277;
    localparam logic [11:0] ADDR_MON_FRAME_CNT   = 12'h278;
    localparam int          SYNC_EN_BIT          = 0;
    localparam int          SYNC_NEXT_BIT        = 1;
    localparam int          PEAK_EN_BIT          = 1;
    localparam int          THR_W                = 13;
    localparam int          DWELL_W              = 16;
    localparam int          PERIOD_W             = 24;
    localparam int          PEAK_W               = 20;
    localparam logic [7:0]  PERIOD_LOW_RESET     = 8'h80;
    localparam logic [23:0] PERIOD_RESET         = {16'h0000, PERIOD_LOW_RESET};

    typedef struct packed {
        logic [THR_W-1:0]   upper;
        logic [THR_W-1:0]   lower;
        logic [DWELL_W-1:0] dwell;
    } fd_cfg_t;

    typedef enum logic [1:0] {
        FD_IDLE  = 2'b00,
        FD_HIGH  = 2'b01,
        FD_DWELL = 2'b10
    } fd_state_t;
endpackage : fdmon_pkg

// file: fd_dwell.sv
// one channel of fast-detect threshold flag with dwell release
// assumes magnitude samples arrive on the output clock with a valid strobe
`timescale 1ns/1ns
module fd_dwell import fdmon_pkg::*; (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire fd_cfg_t          cfg,
    input  wire logic             valid,
    input  wire logic [THR_W-1:0] mag,
    output logic                  flag
);
    fd_state_t          st_q, st_d;
    logic [DWELL_W-1:0] cnt_q, cnt_d;

    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        if (valid) begin
            case (st_q)
                FD_IDLE: begin
                    if (mag > cfg.upper) begin
                        st_d = FD_HIGH;
                    end
                end
                FD_HIGH: begin
                    if (mag < cfg.lower) begin
                        st_d  = FD_DWELL;
                        cnt_d = cfg.dwell;
                    end
                end
                FD_DWELL: begin
                    if (mag > cfg.upper) begin
                        st_d = FD_HIGH;
                    end else if (mag >= cfg.lower) begin
                        cnt_d = cfg.dwell;
                    end else if (cnt_q <= 16'h0001) begin
                        st_d = FD_IDLE;
                    end else begin
                        cnt_d = cnt_q - 16'h0001;
                    end
                end
                default: st_d = FD_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q  <= FD_IDLE;
            cnt_q <= '0;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
        end
    end

    assign flag = (st_q != FD_IDLE);
endmodule : fd_dwell

// file: fdmon_top.sv
// fast-detect dwell logic for two channels and the signal monitor peak detector
// assumes a synchronous byte register port; sysref is an asynchronous pin
// What this block does
// - dwell counter loads programmed value; flag drops after that many samples below lower, after one when the value is zero
// - next-edge cleared resyncs on every rising sysref edge; set uses only first edge
// - in next-edge mode the sync enable bit clears when the edge arrives
// - no monitor sync while enable bit is zero; setting it arms sync
// - peak detector runs only while its enable bit is one
// - monitor period is 24-bit, low byte resets to 0x80, odd values accepted as written too
// - magnitude compared against 13-bit upper and lower thresholds
// - frame counter increments at each period expiry and is readable
`timescale 1ns/1ns
module fdmon_top import fdmon_pkg::*; (
    input  wire logic             MCLK,
    input  wire logic             SYS_RST,
    input  wire logic             REG_WR,
    input  wire logic             REG_RD,
    input  wire logic [11:0]      REG_ADDR,
    input  wire logic [7:0]       REG_WDATA,
    output logic      [7:0]       REG_RDATA,
    input  wire logic             SYSREF,
    input  wire logic             SAMPLE_VALID,
    input  wire logic [THR_W-1:0] MAG_FIRST,
    input  wire logic [THR_W-1:0] MAG_SECOND,
    output logic                  THRESHOLD_FLAG_OUT_FIRST,
    output logic                  THRESHOLD_FLAG_OUT_SECOND
);
    fd_cfg_t             cfg_q, cfg_d;
    logic                sync_en_q, sync_en_d;
    logic                sync_next_q, sync_next_d;
    logic                peak_en_q, peak_en_d;
    logic [PERIOD_W-1:0] period_q, period_d;
    logic [7:0]          rdata_q, rdata_d;
    logic [2:0]          sref_q;
    logic                sref_edge;
    logic                resync;
    logic [PERIOD_W-1:0] pcnt_q, pcnt_d;
    logic [PEAK_W-1:0]   peak_q, peak_d;
    logic [PEAK_W-1:0]   result_q, result_d;
    logic [7:0]          frame_q, frame_d;
    logic                flag_a, flag_b;
    logic                fa_q, fb_q;
    logic [THR_W-1:0]    mag_max;

    // sysref passes two flops before the edge detector reads the second
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            sref_q <= 3'b000;
        end else begin
            sref_q <= {sref_q[1:0], SYSREF};
        end
    end
    assign sref_edge = sref_q[1] & ~sref_q[2];
    assign resync    = sref_edge & sync_en_q;

    always_comb begin
        cfg_d       = cfg_q;
        sync_en_d   = sync_en_q;
        sync_next_d = sync_next_q;
        peak_en_d   = peak_en_q;
        period_d    = period_q;
        if (REG_WR) begin
            case (REG_ADDR)
                ADDR_FD_UP_LOW:       cfg_d.upper[7:0]   = REG_WDATA;
                ADDR_FD_UP_HIGH:      cfg_d.upper[12:8]  = REG_WDATA[4:0];
                ADDR_FD_LOW_LOW:      cfg_d.lower[7:0]   = REG_WDATA;
                ADDR_FD_LOW_HIGH:     cfg_d.lower[12:8]  = REG_WDATA[4:0];
                ADDR_FD_DWELL_LOW:    cfg_d.dwell[7:0]   = REG_WDATA;
                ADDR_FD_DWELL_HIGH:   cfg_d.dwell[15:8]  = REG_WDATA;
                ADDR_MON_SYNC_CTRL: begin
                    sync_en_d   = REG_WDATA[SYNC_EN_BIT];
                    sync_next_d = REG_WDATA[SYNC_NEXT_BIT];
                end
                ADDR_MON_CTRL:        peak_en_d          = REG_WDATA[PEAK_EN_BIT];
                ADDR_MON_PERIOD_LOW:  period_d[7:0]      = REG_WDATA;
                ADDR_MON_PERIOD_MID:  period_d[15:8]     = REG_WDATA;
                ADDR_MON_PERIOD_HIGH: period_d[23:16]    = REG_WDATA;
                default: ;
            endcase
        end
        // hardware clear wins over a same-cycle software write of the enable
        if (resync && sync_next_q) begin
            sync_en_d = 1'b0;
        end
    end

    always_comb begin
        rdata_d = 8'h00;
        if (REG_RD) begin
            case (REG_ADDR)
                ADDR_FD_UP_LOW:       rdata_d = cfg_q.upper[7:0];
                ADDR_FD_UP_HIGH:      rdata_d = {3'b000, cfg_q.upper[12:8]};
                ADDR_FD_LOW_LOW:      rdata_d = cfg_q.lower[7:0];
                ADDR_FD_LOW_HIGH:     rdata_d = {3'b000, cfg_q.lower[12:8]};
                ADDR_FD_DWELL_LOW:    rdata_d = cfg_q.dwell[7:0];
                ADDR_FD_DWELL_HIGH:   rdata_d = cfg_q.dwell[15:8];
                ADDR_MON_SYNC_CTRL:   rdata_d = {6'h00, sync_next_q, sync_en_q};
                ADDR_MON_CTRL:        rdata_d = {6'h00, peak_en_q, 1'b0};
                ADDR_MON_PERIOD_LOW:  rdata_d = period_q[7:0];
                ADDR_MON_PERIOD_MID:  rdata_d = period_q[15:8];
                ADDR_MON_PERIOD_HIGH: rdata_d = period_q[23:16];
                ADDR_MON_PEAK_LOW:    rdata_d = result_q[7:0];
                ADDR_MON_PEAK_MID:    rdata_d = result_q[15:8];
                ADDR_MON_PEAK_HIGH:   rdata_d = {4'h0, result_q[19:16]};
                ADDR_MON_FRAME_CNT:   rdata_d = frame_q;
                default:              rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            cfg_q       <= '0;
            sync_en_q   <= 1'b0;
            sync_next_q <= 1'b0;
            peak_en_q   <= 1'b0;
            period_q    <= PERIOD_RESET;
            rdata_q     <= 8'h00;
        end else begin
            cfg_q       <= cfg_d;
            sync_en_q   <= sync_en_d;
            sync_next_q <= sync_next_d;
            peak_en_q   <= peak_en_d;
            period_q    <= period_d;
            rdata_q     <= rdata_d;
        end
    end
    assign REG_RDATA = rdata_q;

    assign mag_max = (MAG_FIRST > MAG_SECOND) ? MAG_FIRST : MAG_SECOND;

    // period counter counts down; a period of zero or one expires every cycle
    always_comb begin
        pcnt_d   = pcnt_q;
        peak_d   = peak_q;
        result_d = result_q;
        frame_d  = frame_q;
        if (!peak_en_q) begin
            pcnt_d = period_q;
            peak_d = '0;
        end else if (resync) begin
            pcnt_d = period_q;
            peak_d = '0;
        end else if (pcnt_q <= 24'h00_0001) begin
            pcnt_d   = period_q;
            result_d = peak_q;
            peak_d   = '0;
            frame_d  = frame_q + 8'h01;
        end else begin
            pcnt_d = pcnt_q - 24'h00_0001;
            if (SAMPLE_VALID && ({7'h00, mag_max} > peak_q)) begin
                peak_d = {7'h00, mag_max};
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            pcnt_q   <= PERIOD_RESET;
            peak_q   <= '0;
            result_q <= '0;
            frame_q  <= 8'h00;
            fa_q     <= 1'b0;
            fb_q     <= 1'b0;
        end else begin
            pcnt_q   <= pcnt_d;
            peak_q   <= peak_d;
            result_q <= result_d;
            frame_q  <= frame_d;
            fa_q     <= flag_a;
            fb_q     <= flag_b;
        end
    end

    fd_dwell u_fd_first (
        .clk   (MCLK),
        .rst   (SYS_RST),
        .cfg   (cfg_q),
        .valid (SAMPLE_VALID),
        .mag   (MAG_FIRST),
        .flag  (flag_a)
    );

    fd_dwell u_fd_second (
        .clk   (MCLK),
        .rst   (SYS_RST),
        .cfg   (cfg_q),
        .valid (SAMPLE_VALID),
        .mag   (MAG_SECOND),
        .flag  (flag_b)
    );

    assign THRESHOLD_FLAG_OUT_FIRST  = fa_q;
    assign THRESHOLD_FLAG_OUT_SECOND = fb_q;
endmodule : fdmon_top

// file: fdmon_checker.sv
// port-level checks for fdmon_top
// assumes a bind from the bench; everything is quiet while SYS_RST is high
`timescale 1ns/1ns
module fdmon_checker import fdmon_pkg::*; (
    input wire logic        MCLK,
    input wire logic        SYS_RST,
    input wire logic        REG_WR,
    input wire logic        REG_RD,
    input wire logic [11:0] REG_ADDR,
    input wire logic [7:0]  REG_WDATA,
    input wire logic [7:0]  REG_RDATA,
    input wire logic        SAMPLE_VALID,
    input wire logic        THRESHOLD_FLAG_OUT_FIRST,
    input wire logic        THRESHOLD_FLAG_OUT_SECOND
);
    wire logic [1:0] fl = {THRESHOLD_FLAG_OUT_SECOND, THRESHOLD_FLAG_OUT_FIRST};
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    // flags only move one or two cycles after a sample
    sequence sample_seen;
        $past(SAMPLE_VALID) || $past(SAMPLE_VALID, 2);
    endsequence
    AST_FLAG_A_CAUSE: assert property ($changed(fl[0]) |-> sample_seen)
        else $error("first flag moved with no sample");
    AST_FLAG_B_CAUSE: assert property ($changed(fl[1]) |-> sample_seen)
        else $error("second flag moved with no sample");
    AST_RD_IDLE: assert property (!REG_RD |=> REG_RDATA == 8'h00)
        else $error("read data not idle");
    AST_UNMAPPED: assert property (REG_RD && REG_ADDR == 12'h274 |=> REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    AST_SYNC_RSVD: assert property (REG_RD && REG_ADDR == ADDR_MON_SYNC_CTRL |=>
        REG_RDATA[7:2] == 6'h00) else $error("sync control reserved bits set");
    AST_CTRL_RSVD: assert property (REG_RD && REG_ADDR == ADDR_MON_CTRL |=>
        REG_RDATA[7:2] == 6'h00 && !REG_RDATA[0]) else $error("control reserved bits set");
    AST_DWELL_BACK: assert property (REG_WR && REG_ADDR == ADDR_FD_DWELL_LOW ##2
        REG_RD && REG_ADDR == ADDR_FD_DWELL_LOW |=> REG_RDATA == $past(REG_WDATA, 3))
        else $error("dwell readback wrong");
    AST_PERIOD_BACK: assert property (REG_WR && REG_ADDR == ADDR_MON_PERIOD_LOW ##2
        REG_RD && REG_ADDR == ADDR_MON_PERIOD_LOW |=> REG_RDATA == $past(REG_WDATA, 3))
        else $error("period readback wrong");
    cover property ($rose(THRESHOLD_FLAG_OUT_FIRST));
    cover property ($fell(THRESHOLD_FLAG_OUT_SECOND));
    cover property (REG_RD && REG_ADDR == ADDR_MON_FRAME_CNT);
endmodule : fdmon_checker

// file: fdmon_partner.sv
// sysref source standing in for the board timing source
// assumes the bench sets the half period in output clock cycles
`timescale 1ns/1ns
module fdmon_partner (
    input  wire logic       clk,
    input  wire logic       en,
    input  wire logic [7:0] half,
    output logic            sysref = 1'b0
);
    logic [7:0] cnt_q = 8'h00;
    always @(posedge clk) begin
        if (!en) begin
            cnt_q <= 8'h00;
            sysref <= 1'b0;
        end else if (cnt_q + 8'h01 >= half) begin
            cnt_q <= 8'h00;
            sysref <= ~sysref;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule : fdmon_partner

// file: test_adc_fast_detect_signal_monitor.sv
// bench for the fast-detect flags and signal monitor
// assumes fdmon_top, fdmon_checker and fdmon_partner are compiled first
`timescale 1ns/1ns
module test_adc_fast_detect_signal_monitor import fdmon_pkg::*; ;
    logic             MCLK = 1'b0, SYS_RST = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0;
    logic [11:0]      REG_ADDR = 12'h000;
    logic [7:0]       REG_WDATA = 8'h00, REG_RDATA, sent = 8'h00, seen = 8'h00, n;
    logic             SYSREF, SAMPLE_VALID = 1'b0, rd_seen = 1'b0, sr_en = 1'b0, fa, fb;
    logic [THR_W-1:0] MAG_FIRST = 13'h0000, MAG_SECOND = 13'h0000, m;
    logic [31:0]      rnd = 32'h6130;
    logic [1:0]       last_fl = 2'b00;
    logic [7:0]       rd_q[$];
    logic [9:0]       fl_q[$];
    int               miscompares = 0, checks_done = 0, cycles = 0;
    always #2 MCLK = ~MCLK;
    fdmon_top fdmon_top_i (.MCLK(MCLK), .SYS_RST(SYS_RST), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .SYSREF(SYSREF),
        .SAMPLE_VALID(SAMPLE_VALID), .MAG_FIRST(MAG_FIRST), .MAG_SECOND(MAG_SECOND),
        .THRESHOLD_FLAG_OUT_FIRST(fa), .THRESHOLD_FLAG_OUT_SECOND(fb));
    // sysref every 12 cycles on purpose: no multiple of the monitor period
    fdmon_partner fdmon_partner_i (.clk(MCLK), .en(sr_en), .half(8'h06), .sysref(SYSREF));
    task automatic end_of_test();
        if (miscompares == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int c);
        repeat (c) @(posedge MCLK);
        #1;
    endtask : tick
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        REG_WR = 1'b1;
        REG_ADDR = a;
        REG_WDATA = d;
        tick(1);
        REG_WR = 1'b0;
        tick(1);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        REG_RD = 1'b1;
        REG_ADDR = a;
        tick(1);
        REG_RD = 1'b0;
        tick(1);
    endtask : rd
    function automatic logic [12:0] rn(input logic [12:0] mask);
        rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
        return rnd[12:0] & mask;
    endfunction : rn
    // the other channel always gets a quiet value below the lower threshold
    task automatic smp(input int k, input logic [12:0] v);
        SAMPLE_VALID = 1'b1;
        MAG_FIRST = (k == 0) ? v : rn(13'h007f);
        MAG_SECOND = (k == 1) ? v : rn(13'h007f);
        sent++;
        tick(1);
        SAMPLE_VALID = 1'b0;
        tick(3);
    endtask : smp
    always @(posedge MCLK) begin
        rd_seen <= REG_RD;
        seen <= seen + 8'(SAMPLE_VALID);
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            end_of_test();
        end
    end
    always @(negedge MCLK) begin
        if (rd_seen)
            chk({2'b00, REG_RDATA}, {2'b00, rd_q.pop_front()});
        if ({fb, fa} !== last_fl) begin
            last_fl = {fb, fa};
            chk({seen, last_fl}, fl_q.pop_front());
        end
    end
    initial begin
        tick(3);
        SYS_RST = 1'b0;
        rd(ADDR_MON_PERIOD_LOW, PERIOD_LOW_RESET);
        rd(12'h274, 8'h00);
        wr(ADDR_MON_SYNC_CTRL, 8'hfc);
        rd(ADDR_MON_SYNC_CTRL, 8'h00);
        wr(ADDR_MON_CTRL, 8'hff);
        rd(ADDR_MON_CTRL, 8'h02);
        wr(ADDR_MON_PERIOD_LOW, 8'h36);
        rd(ADDR_MON_PERIOD_LOW, 8'h36);
        wr(ADDR_MON_CTRL, 8'h00);
        wr(ADDR_FD_UP_HIGH, 8'h01);
        wr(ADDR_FD_LOW_LOW, 8'h80);
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_FD_DWELL_LOW, k ? 8'h00 : 8'h03);
            rd(ADDR_FD_DWELL_LOW, k ? 8'h00 : 8'h03);
            smp(k, 13'h0100);
            fl_q.push_back({sent + 8'h01, 2'b01 << k});
            smp(k, 13'h0101 + rn(13'h00ff));
            smp(k, rn(13'h007f));
            smp(k, 13'h0080);
            // after an in-range reload the flag drops on the dwell-th sample below lower, the first when dwell is zero
            n = k ? 8'h01 : 8'h03;
            fl_q.push_back({sent + n, 2'b00});
            repeat (n) smp(k, rn(13'h007f));
        end
        SYS_RST = 1'b1;
        tick(3);
        SYS_RST = 1'b0;
        wr(ADDR_FD_UP_LOW, 8'hff);
        wr(ADDR_FD_UP_HIGH, 8'h1f);
        m = rn(13'h0fff) | 13'h0100;
        MAG_FIRST = m;
        MAG_SECOND = m >> 1;
        SAMPLE_VALID = 1'b1;
        sr_en = 1'b1;
        wr(ADDR_MON_PERIOD_LOW, 8'h10);
        wr(ADDR_MON_SYNC_CTRL, 8'h01);
        wr(ADDR_MON_CTRL, 8'h02);
        tick(200);
        rd(ADDR_MON_FRAME_CNT, 8'h00);
        rd(ADDR_MON_SYNC_CTRL, 8'h01);
        wr(ADDR_MON_CTRL, 8'h00);
        wr(ADDR_MON_SYNC_CTRL, 8'h00);
        wr(ADDR_MON_CTRL, 8'h02);
        // window of six and a half periods keeps the expected count clear of edges
        tick(102);
        wr(ADDR_MON_CTRL, 8'h00);
        tick(40);
        rd(ADDR_MON_FRAME_CNT, 8'h06);
        rd(ADDR_MON_PEAK_LOW, m[7:0]);
        rd(ADDR_MON_PEAK_MID, {3'b000, m[12:8]});
        wr(ADDR_MON_SYNC_CTRL, 8'h03);
        tick(40);
        rd(ADDR_MON_SYNC_CTRL, 8'h02);
        sr_en = 1'b0;
        tick(4);
        if (rd_q.size() + fl_q.size() != 0)
            miscompares++;
        end_of_test();
    end
endmodule : test_adc_fast_detect_signal_monitor
bind fdmon_top fdmon_checker fdmon_checker_i (.MCLK(MCLK), .SYS_RST(SYS_RST), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .SAMPLE_VALID(SAMPLE_VALID), .THRESHOLD_FLAG_OUT_FIRST(THRESHOLD_FLAG_OUT_FIRST),
    .THRESHOLD_FLAG_OUT_SECOND(THRESHOLD_FLAG_OUT_SECOND));
